/* hw/irp_params.svh */
// constants for the indirect register portal
// How it works
// - The portal reaches up to 32 indirect devices of up to 65,536 registers of 16 bits each.
// - Control bits 15:14 pick the meaning of the data register: 00 means address, else data.
// - In mode 01 every data access hits the selected register and leaves the address alone.
// - In mode 10 the stored address steps up by one after every data read and data write.
// - In mode 11 the stored address steps up only after data writes, never after reads.
// - Control bits 4:0 name the indirect device that all following data accesses outside mode 00 go to.
// - In mode 00 a data write stores the target address and a data read returns it.
// - Outside mode 00 a data read returns the selected register and a data write updates it.
// - Reads with post-increment return successive registers, starting at the stored address.
`ifndef IRP_PARAMS_SVH
`define IRP_PARAMS_SVH
`define IRP_CTRL_OFS 5'h0D
`define IRP_DATA_OFS 5'h0E
`define IRP_CTRL_RST 16'h0000
`define IRP_DATA_RST 16'h0000
`define IRP_OP_REG 2'h0
`define IRP_OP_DATA 2'h1
`define IRP_OP_INC_RW 2'h2
`define IRP_OP_INC_WR 2'h3
`define IRP_NUM_REGS 8
`define IRP_KEY_0 21'h01_0000
`define IRP_KEY_1 21'h07_003C
`define IRP_KEY_2 21'h07_003D
`define IRP_KEY_3 21'h1C_0004
`define IRP_KEY_4 21'h1F_0000
`define IRP_KEY_5 21'h1F_0019
`define IRP_KEY_6 21'h1F_001A
`define IRP_KEY_7 21'h1F_001B
`endif

/* hw/irp_pkg.sv */
// types shared by the indirect register portal
package irp_pkg;
  typedef logic [1:0] irp_op_t;
  typedef struct packed {
    irp_op_t op;
    logic [8:0] spare;
    logic [4:0] dev;
  } irp_ctrl_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } irp_req_s;
endpackage : irp_pkg

/* hw/irp_store.sv */
// backing store for the supported indirect registers
`timescale 1ns/1ns
`include "irp_params.svh"
module irp_store (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] dev,
  input wire logic [15:0] addr,
  input wire logic wr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  localparam logic [20:0] KEYS [`IRP_NUM_REGS] = '{`IRP_KEY_0, `IRP_KEY_1, `IRP_KEY_2,
    `IRP_KEY_3, `IRP_KEY_4, `IRP_KEY_5, `IRP_KEY_6, `IRP_KEY_7};
  logic [15:0] mem [`IRP_NUM_REGS];
  logic hit;
  logic [2:0] idx;
  logic [20:0] key;

  assign key = {dev, addr};

  // sparse lookup; anything outside the table reads zero
  always_comb begin
    hit = 1'b0;
    idx = 3'h0;
    for (int i = 0; i < `IRP_NUM_REGS; i++) begin
      if (key == KEYS[i]) begin
        hit = 1'b1;
        idx = i[2:0];
      end
    end
    rdata = hit ? mem[idx] : 16'h0000;
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < `IRP_NUM_REGS; i++) begin
      if (rst) begin
        mem[i] <= 16'h0000;
      end else if (wr && key == KEYS[i]) begin
        mem[i] <= wdata;
      end
    end
  end

  chk_miss_reads_zero: assert property (@(posedge clock) disable iff (rst)
    !hit |-> rdata == 16'h0000) else $error("unsupported register did not read zero");
  chk_write_lands: assert property (@(posedge clock) disable iff (rst)
    wr && hit |=> mem[$past(idx)] == $past(wdata)) else $error("store write was lost");
endmodule : irp_store

/* hw/irp_portal.sv */
// indirect register portal behind the management register port
`timescale 1ns/1ns
`include "irp_params.svh"
module irp_portal (
  input wire logic clock,
  input wire logic rst,
  input wire irp_pkg::irp_req_s req,
  output logic [15:0] rd_data_q,
  output logic rd_valid_q
);
  irp_pkg::irp_ctrl_s ctrl_q;
  logic [15:0] addr_q;
  logic [15:0] store_rdata;
  logic sel_ctrl;
  logic sel_data;
  logic wr_ctrl;
  logic wr_data;
  logic rd_any;
  logic rd_data;
  logic rd_ctrl;
  logic reg_mode;
  logic step;

  assign sel_ctrl = req.addr == `IRP_CTRL_OFS;
  assign sel_data = req.addr == `IRP_DATA_OFS;
  // a write in the same cycle wins; the read is dropped
  assign rd_any = req.rd && !req.wr;
  assign wr_ctrl = req.wr && sel_ctrl;
  assign wr_data = req.wr && sel_data;
  assign rd_data = rd_any && sel_data;
  assign rd_ctrl = rd_any && sel_ctrl;
  assign reg_mode = ctrl_q.op == `IRP_OP_REG;
  // reads step only in mode 10, writes in 10 and 11
  assign step = (wr_data && (ctrl_q.op == `IRP_OP_INC_RW || ctrl_q.op == `IRP_OP_INC_WR))
    || (rd_data && ctrl_q.op == `IRP_OP_INC_RW);

  // reserved control bits are kept as written
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= irp_pkg::irp_ctrl_s'(`IRP_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q <= irp_pkg::irp_ctrl_s'(req.wdata);
    end
  end

  // one address shared by all devices, so switching device keeps it
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_q <= `IRP_DATA_RST;
    end else if (wr_data && reg_mode) begin
      addr_q <= req.wdata;
    end else if (step) begin
      addr_q <= addr_q + 16'h0001;
    end
  end

  irp_store u_store (
    .clock(clock),
    .rst(rst),
    .dev(ctrl_q.dev),
    .addr(addr_q),
    .wr(wr_data && !reg_mode),
    .wdata(req.wdata),
    .rdata(store_rdata)
  );

  // any read answers one cycle later; foreign offsets read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= rd_any;
      if (rd_ctrl) begin
        rd_data_q <= ctrl_q;
      end else if (rd_data) begin
        rd_data_q <= reg_mode ? addr_q : store_rdata;
      end else if (rd_any) begin
        rd_data_q <= 16'h0000;
      end
    end
  end

  // checking aid: address model decoded per mode, kept apart from step
  logic [15:0] model_addr_q;
  logic [15:0] model_ctrl_q;
  logic model_is_write;
  logic model_is_read;
  logic model_data_hit;

  assign model_is_write = req.wr && req.addr == `IRP_DATA_OFS;
  assign model_is_read = req.rd && !req.wr && req.addr == `IRP_DATA_OFS;
  assign model_data_hit = model_is_write || model_is_read;

  // mode decoded by case so a slip in the step term shows up here
  always_ff @(posedge clock) begin
    if (rst) begin
      model_addr_q <= 16'h0000;
    end else begin
      case (ctrl_q.op)
        `IRP_OP_REG: begin
          if (model_is_write) begin
            model_addr_q <= req.wdata;
          end
        end
        `IRP_OP_DATA: begin
          model_addr_q <= model_addr_q;
        end
        `IRP_OP_INC_RW: begin
          if (model_data_hit) begin
            model_addr_q <= model_addr_q + 16'h0001;
          end
        end
        default: begin
          if (model_is_write) begin
            model_addr_q <= model_addr_q + 16'h0001;
          end
        end
      endcase
    end
  end

  // checking aid: control image taken straight from the port
  always_ff @(posedge clock) begin
    if (rst) begin
      model_ctrl_q <= 16'h0000;
    end else if (req.wr && req.addr == `IRP_CTRL_OFS) begin
      model_ctrl_q <= req.wdata;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_read_latency: assert property (
    rd_any |=> rd_valid_q ##1 !rd_valid_q || $past(rd_any)) else $error("read answer missing");

  chk_reg_mode_read: assert property (
    rd_data && reg_mode |=> rd_data_q == $past(addr_q)) else $error("address readback wrong");

  chk_addr_store: assert property (
    wr_data && reg_mode |=> addr_q == $past(req.wdata)) else $error("address not stored");

  chk_mode01_hold: assert property (
    (rd_data || wr_data) && ctrl_q.op == `IRP_OP_DATA |=> $stable(addr_q))
    else $error("address moved in mode 01");

  chk_inc_rw_step: assert property (
    (rd_data || wr_data) && ctrl_q.op == `IRP_OP_INC_RW |=> addr_q == $past(addr_q) + 16'h0001)
    else $error("no step in mode 10");

  chk_inc_wr_read: assert property (
    rd_data && ctrl_q.op == `IRP_OP_INC_WR |=> $stable(addr_q)) else $error("read stepped in 11");

  chk_inc_wr_write: assert property (
    wr_data && ctrl_q.op == `IRP_OP_INC_WR |=> addr_q == $past(addr_q) + 16'h0001)
    else $error("write did not step in 11");

  chk_ctrl_keeps_addr: assert property (
    wr_ctrl |=> $stable(addr_q)) else $error("control write moved address");

  chk_data_read: assert property (
    rd_data && !reg_mode |=> rd_data_q == $past(store_rdata)) else $error("data read wrong");

  chk_ctrl_read: assert property (
    rd_ctrl |=> rd_data_q == $past(ctrl_q)) else $error("control readback wrong");

  // reset is checked on its own, so the default disable is switched off here
  chk_reset_state: assert property (disable iff (1'b0)
    rst |=> !rd_valid_q && rd_data_q == 16'h0000 && addr_q == 16'h0000
      && ctrl_q == 16'h0000)
    else $error("reset state wrong");

  chk_no_read_quiet: assert property (
    !rd_any |=> !rd_valid_q)
    else $error("answer without read");

  chk_valid_has_read: assert property (
    rd_valid_q |-> $past(rd_any))
    else $error("answer has no read behind it");

  // a write wins, so a collided read must stay silent
  chk_read_drop: assert property (
    req.rd && req.wr |=> !rd_valid_q)
    else $error("collided read answered");

  chk_answer_holds: assert property (
    !rd_any |=> $stable(rd_data_q))
    else $error("read data moved without read");

  chk_ctrl_write: assert property (
    wr_ctrl |=> ctrl_q == $past(req.wdata))
    else $error("control write lost");

  chk_ctrl_model: assert property (
    ctrl_q == model_ctrl_q)
    else $error("control differs from model");

  chk_addr_idle: assert property (
    !wr_data && !rd_data |=> $stable(addr_q))
    else $error("address moved while idle");

  chk_reg_read_hold: assert property (
    rd_data && reg_mode |=> $stable(addr_q))
    else $error("address read stepped");

  chk_addr_model: assert property (
    addr_q == model_addr_q)
    else $error("address differs from model");

  // address is 16 bits wide, so a step past the top wraps to zero
  chk_step_wrap: assert property (
    step && addr_q == 16'hFFFF |=> addr_q == 16'h0000)
    else $error("address wrap wrong");

  chk_foreign_read: assert property (
    rd_any && !sel_ctrl && !sel_data |=> rd_valid_q && rd_data_q == 16'h0000)
    else $error("foreign offset not zero");
endmodule : irp_portal

/* testbench/irp_host.sv */
// station management host model on the portal register port
`timescale 1ns/1ns
`include "irp_params.svh"
module irp_host (
  input wire logic clock,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_valid_q,
  output irp_pkg::irp_req_s req
);
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    req.wr <= 1'b0;
    req.wdata <= ~d; // released bus keeps no stale value
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [16:0] r);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, req.wdata};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 r = {rd_valid_q, rd_data_q}; // answer is registered at the taking edge
  endtask : rd
  task automatic go(input logic [4:0] v, input logic [15:0] ra, input logic [1:0] m);
    wr(`IRP_CTRL_OFS, {`IRP_OP_REG, 9'h000, v});
    wr(`IRP_DATA_OFS, ra);
    wr(`IRP_CTRL_OFS, {m, 9'h000, v});
  endtask : go
endmodule : irp_host

/* testbench/irp_portal_tb.sv */
// self-checking bench for the indirect register portal
`timescale 1ns/1ns
module irp_portal_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] rd_data_q, v;
  logic [15:0] w [3];
  logic rd_valid_q;
  logic [16:0] r;
  irp_pkg::irp_req_s req;
  int err_total = 0;
  int total_checks = 0;
  always #2 clock = ~clock;
  irp_portal uut (.clock(clock), .rst(rst), .req(req), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q));
  irp_host host (.clock(clock), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .req(req));
  task automatic cmp(input string n, input logic [16:0] s, input logic [16:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // traffic needs about 70 cycles, so this is generous
  initial begin
    repeat (2000) @(posedge clock);
    err_total++;
    wrap_up();
  end
  initial begin
    v = 16'($urandom(79331));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    host.rd(5'h0D, r);
    cmp("ctrl", r, 17'h1_0000);
    host.rd(5'h0E, r);
    cmp("data", r, 17'h1_0000);
    host.rd(5'h03, r);
    cmp("foreign", r, 17'h1_0000);
    $display("reset done");
    host.go(5'h1F, 16'h0000, 2'h1);
    host.wr(5'h0E, v);
    host.rd(5'h0E, r);
    cmp("1f.0", r, {1'b1, v});
    $display("single done");
    host.go(5'h1F, 16'h0019, 2'h3);
    foreach (w[i]) begin
      w[i] = 16'($urandom);
      host.wr(5'h0E, w[i]);
    end
    host.rd(5'h0E, r);
    cmp("1f.1c", r, 17'h1_0000);
    host.wr(5'h0D, 16'h001F);
    host.rd(5'h0E, r);
    cmp("addr", r, 17'h1_001C);
    host.go(5'h1F, 16'h0019, 2'h2);
    foreach (w[i]) begin
      host.rd(5'h0E, r);
      cmp("burst", r, {1'b1, w[i]});
    end
    host.wr(5'h0D, 16'h001F);
    host.rd(5'h0E, r);
    cmp("addr", r, 17'h1_001C);
    $display("step done");
    host.go(5'h02, 16'h0000, 2'h1);
    host.wr(5'h0E, ~v);
    host.rd(5'h0E, r);
    cmp("dev 2", r, 17'h1_0000);
    host.wr(5'h0D, 16'h401F);
    host.rd(5'h0E, r);
    cmp("dev 1f", r, {1'b1, v});
    $display("device done");
    wrap_up();
  end
endmodule : irp_portal_tb
